/* File: fan_model.sv */
// cooling fan model that measures the pwm waveform
`timescale 1ns/10ps
`default_nettype none
// ==========
// fan
module fan_model
(
  // clock and pin
  input  wire logic        clk_i,
  input  wire logic        pwm_i,
  // last full period, its high time and the count of rises
  output var  logic [31:0] per_o,
  output var  logic [31:0] hi_o,
  output var  logic [31:0] rises_o
);
  logic [31:0] cnt;
  logic [31:0] hcnt;
  logic        last;
  // this fan has no tach output, so no tach mode restriction arises
  initial {per_o, hi_o, rises_o, cnt, hcnt, last} = '0;
  always @(posedge clk_i)
  begin
    last <= pwm_i;
    cnt <= (pwm_i && !last) ? 32'h1 : cnt + 32'h1;
    hcnt <= (pwm_i && !last) ? 32'h1 : hcnt + {31'h0, pwm_i};
    if (pwm_i && !last)
    begin
      per_o <= cnt;
      hi_o <= hcnt;
      rises_o <= rises_o + 32'h1;
    end
  end
endmodule // fan_model
`default_nettype wire

/* File: fan_pwm_map.vh */
// register map, field positions and timing constants of the fan pwm output stage
`ifndef FAN_PWM_MAP_VH
`define FAN_PWM_MAP_VH

// ============================================================
// register indices (byte address is four times the index)
`define RT_CLAMP_IDX    8'h5b
`define PWM_CFG_IDX     8'h60
`define PWM_STAT_IDX    8'h61
`define ADR_HI_ZERO     2'b00

// ============================================================
// fields and reset values
`define CLAMP_BIT       7
`define CLAMP_RST       1'b0
`define FSEL_MSB        3
`define FSEL_RST        4'ha
`define DUTY_RST        8'h00
`define STAT_CLAMP_BIT  0
`define STAT_ODUTY_LSB  8
`define STAT_RDUTY_LSB  16
`define STAT_CDUTY_LSB  24

// ============================================================
// clock rates and timing
`define SYS_KHZ         15'd20000
`define REF_KHZ         15'd14318
`define DUTY_CLK_KHZ    8'd90
`define DIV_90K         8'd159
`define CLAMP_MS        2000
`define CLAMP_CYC_W     26

// ============================================================
// pwm periods in reference-clock ticks, low then high frequencies
`define PER_W           21
`define PER_11_0HZ      21'd1301636
`define PER_14_6HZ      21'd980685
`define PER_21_9HZ      21'd653790
`define PER_29_3HZ      21'd488669
`define PER_35_2HZ      21'd406761
`define PER_44_0HZ      21'd325409
`define PER_58_6HZ      21'd244334
`define PER_87_7HZ      21'd163261
`define PER_15KHZ       21'd955
`define PER_20KHZ       21'd716
`define PER_25KHZ       21'd573
`define PER_30KHZ       21'd477

`endif

/* File: fan_pwm_monitor.sv */
// port checker of the fan pwm output stage
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker
module fan_pwm_monitor
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // bus and pin
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pwm_o
);
  int gap = 0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the last pwm rising edge
  always @(posedge sys_clk_i)
    gap <= (rst_i || $rose(pwm_o)) ? 0 : gap + 1;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd_ack; wb_ack_o && !wb_we_i; endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped; s_rd_ack ##0 !(wb_adr_i[11:2] inside {10'h05b, 10'h060, 10'h061})
    |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dat_hold; !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_rel_low; $fell(rst_i) |-> !pwm_o [*8]; endproperty
  a_rel_low: assert property (p_rel_low) else $error("pin high after reset");
  property p_rst_low; disable iff (1'b0) rst_i |=> !pwm_o && !wb_ack_o; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset not applied");
  property p_gap; $rose(pwm_o) |-> gap >= 600; endproperty
  a_gap: assert property (p_gap) else $error("pwm period too short");
endmodule // fan_pwm_monitor
bind fan_pwm_output_stage fan_pwm_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o));
`default_nettype wire

/* File: fan_pwm_output_stage.v */
// fan pwm output stage: reference divider, duty latching, power-on clamp, wishbone registers
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "fan_pwm_map.vh"

// Notes on behaviour
// (R1) pin duty changes only at a pwm rising edge, taking the ramping duty then
// (R2) calculated, ramping and output duty registers each update on the 90 kHz tick
// (R3) after main power-on reset the pin is held low for zero or two seconds
// (R4) clamp select bit lives in battery-backed storage, unaffected by main reset
// (R5) clamp select is bit 7 of the runtime register at index 5Bh
// (R6) select bit 1 means no delay; 0, the default, means a two second delay
// (R7) software uses tach mode 1 only when driving a tach fan at high frequency
// (R8) eight low frequencies from 11.0 Hz up to 87.7 Hz
// (R9) four high frequencies: 15, 20, 25 and 30 kHz
// (R10) all pwm frequencies are divided down from the 14.318 MHz reference
// (R11) a four-bit select field chooses the output frequency
// (R12) out of reset the select field chooses 25 kHz
// (R13) select codes map to periods through a lookup table of divider values
module fan_pwm_output_stage
#(
  parameter CLAMP_CYCLES = `CLAMP_MS * `SYS_KHZ
)
(
  // clock and resets
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        vbat_rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // duty values from the ramp block
  input  wire [7:0]  calc_duty_i,
  input  wire [7:0]  ramp_duty_i,
  // fan pin
  output reg         pwm_o
);

  // ==========================================================
  // state machine codes
  localparam [1:0] ST_CLAMP = 2'b01;
  localparam [1:0] ST_RUN   = 2'b10;

  // ==========================================================
  // declarations
  reg  [14:0]             ref_acc;
  reg  [15:0]             next_ref_acc;
  reg                     ref_tick;
  reg  [7:0]              div90;
  reg                     tick90;
  reg                     clamp_sel;
  reg  [3:0]              freq_sel;
  reg  [7:0]              calc_duty;
  reg  [7:0]              ramp_duty;
  reg  [7:0]              out_duty;
  reg                     latch_pend;
  reg  [`PER_W-1:0]       period;
  reg  [`PER_W-1:0]       phase;
  reg  [`PER_W-1:0]       high_len;
  reg  [`PER_W-1:0]       next_period;
  wire [`PER_W+7:0]       duty_prod;
  wire                    wrap;
  reg  [1:0]              state;
  reg  [`CLAMP_CYC_W-1:0] clamp_cnt;
  wire                    clamp_on;
  wire                    bus_req;
  wire                    bus_wr;
  wire                    hit_rt;
  wire                    hit_cfg;
  wire                    hit_stat;
  reg  [31:0]             next_rdata;

  // ==========================================================
  // reference clock: 14.318 MHz tick built from the 20 MHz clock
  always @*
  begin
    next_ref_acc = {1'b0, ref_acc} + {1'b0, `REF_KHZ};
  end

  // (R10) fractional divide to reference rate
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ref_acc  <= 15'h0000;
      ref_tick <= 1'b0;
    end
    else if (next_ref_acc >= {1'b0, `SYS_KHZ})
    begin
      ref_acc  <= next_ref_acc[14:0] - `SYS_KHZ;
      ref_tick <= 1'b1;
    end
    else
    begin
      ref_acc  <= next_ref_acc[14:0];
      ref_tick <= 1'b0;
    end
  end

  // ==========================================================
  // 90 kHz duty clock tick from the reference
  // (R2) duty logic clock divider
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      div90  <= 8'h00;
      tick90 <= 1'b0;
    end
    else if (ref_tick && div90 == `DIV_90K - 8'h01)
    begin
      div90  <= 8'h00;
      tick90 <= 1'b1;
    end
    else
    begin
      tick90 <= 1'b0;
      if (ref_tick)
        div90 <= div90 + 8'h01;
    end
  end

  // ==========================================================
  // duty registers
  // (R2) calculated and ramping duty sampled on the 90 kHz tick
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      calc_duty <= `DUTY_RST;
      ramp_duty <= `DUTY_RST;
    end
    else if (tick90)
    begin
      calc_duty <= calc_duty_i;
      ramp_duty <= ramp_duty_i;
    end
  end

  // (R2) status copy of the pin duty, latched on the duty tick after an edge
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      out_duty   <= `DUTY_RST;
      latch_pend <= 1'b0;
    end
    else
    begin
      if (tick90 && latch_pend)
        out_duty <= ramp_duty;
      // a new rising edge in the latching cycle keeps the request
      if (wrap)
        latch_pend <= 1'b1;
      else if (tick90)
        latch_pend <= 1'b0;
    end
  end

  // ==========================================================
  // frequency lookup
  // (R13) select code to period table
  always @*
  begin
    case (freq_sel)
      // (R8) low frequencies
      4'h0:    next_period = `PER_11_0HZ;
      4'h1:    next_period = `PER_14_6HZ;
      4'h2:    next_period = `PER_21_9HZ;
      4'h3:    next_period = `PER_29_3HZ;
      4'h4:    next_period = `PER_35_2HZ;
      4'h5:    next_period = `PER_44_0HZ;
      4'h6:    next_period = `PER_58_6HZ;
      4'h7:    next_period = `PER_87_7HZ;
      // (R9) high frequencies
      4'h8:    next_period = `PER_15KHZ;
      4'h9:    next_period = `PER_20KHZ;
      4'ha:    next_period = `PER_25KHZ;
      4'hb:    next_period = `PER_30KHZ;
      default: next_period = `PER_25KHZ;
    endcase
  end

  // ==========================================================
  // pwm period counter and compare
  assign wrap      = ref_tick && (phase == period - {{(`PER_W-1){1'b0}}, 1'b1});
  assign duty_prod = next_period * ramp_duty;

  // (R10) period counts reference ticks; select applies at period end
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      phase    <= {`PER_W{1'b0}};
      period   <= `PER_25KHZ;
      high_len <= {`PER_W{1'b0}};
    end
    else
    begin
      if (wrap)
      begin
        phase    <= {`PER_W{1'b0}};
        period   <= next_period;
        // (R1) pin duty taken from the ramping duty at the rising edge
        high_len <= duty_prod[`PER_W+7:8];
      end
      else if (ref_tick)
        phase <= phase + {{(`PER_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // power-on clamp
  assign clamp_on = (state == ST_CLAMP);

  // (R3) hold low after main reset
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state     <= ST_CLAMP;
      clamp_cnt <= {`CLAMP_CYC_W{1'b0}};
    end
    else
    begin
      case (state)
        ST_CLAMP:
        begin
          // (R6) bypass bit 1 skips the delay
          if (clamp_sel || clamp_cnt == CLAMP_CYCLES[`CLAMP_CYC_W-1:0] - 1'b1)
            state <= ST_RUN;
          clamp_cnt <= clamp_cnt + {{(`CLAMP_CYC_W-1){1'b0}}, 1'b1};
        end
        ST_RUN:
          state <= ST_RUN;
        default:
          state <= ST_CLAMP;
      endcase
    end
  end

  // pin drive
  // (R1) high time fixed for the whole period, so no extra rising edge
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= !clamp_on && (phase < high_len);
  end

  // ==========================================================
  // wishbone register file
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // write lands at the edge where the master samples ack
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  // (R5) runtime register index decode
  assign hit_rt   = wb_adr_i[11:2] == {`ADR_HI_ZERO, `RT_CLAMP_IDX};
  assign hit_cfg  = wb_adr_i[11:2] == {`ADR_HI_ZERO, `PWM_CFG_IDX};
  assign hit_stat = wb_adr_i[11:2] == {`ADR_HI_ZERO, `PWM_STAT_IDX};

  // (R4) battery-side storage, cleared only by the battery reset
  always @(posedge sys_clk_i)
  begin
    if (vbat_rst_i)
      clamp_sel <= `CLAMP_RST;
    // (R5) bit 7 of the runtime register
    else if (bus_wr && hit_rt)
      clamp_sel <= wb_dat_i[`CLAMP_BIT];
  end

  // (R11) four-bit frequency select
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      // (R12) 25 kHz out of reset
      freq_sel <= `FSEL_RST;
    else if (bus_wr && hit_cfg)
      freq_sel <= wb_dat_i[`FSEL_MSB:0];
  end

  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (hit_rt)
      next_rdata[`CLAMP_BIT] = clamp_sel;
    else if (hit_cfg)
      next_rdata[`FSEL_MSB:0] = freq_sel;
    else if (hit_stat)
    begin
      next_rdata[`STAT_CLAMP_BIT]                    = clamp_on;
      next_rdata[`STAT_ODUTY_LSB+7:`STAT_ODUTY_LSB] = out_duty;
      next_rdata[`STAT_RDUTY_LSB+7:`STAT_RDUTY_LSB] = ramp_duty;
      next_rdata[`STAT_CDUTY_LSB+7:`STAT_CDUTY_LSB] = calc_duty;
    end
  end

  // one wait state: ack and data one edge after the request
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

endmodule // fan_pwm_output_stage
`default_nettype wire

/* File: test_fan_pwm_output_stage.sv */
// self-checking testbench of the fan pwm output stage
`timescale 1ns/10ps
`default_nettype none
`include "fan_pwm_map.vh"
// ==========
// bench
module test_fan_pwm_output_stage;
  logic        sys_clk_i = 0, rst_i = 1, vbat_rst_i = 1;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, q, per, hi, rises;
  logic [7:0]  calc_duty_i = 8'h0, ramp_duty_i = 8'h80;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, pwm_o;
  int          mismatches = 0, checks_done = 0;
  int          rel_cyc = 0;
  fan_pwm_output_stage #(.CLAMP_CYCLES(4000)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .vbat_rst_i(vbat_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .calc_duty_i(calc_duty_i), .ramp_duty_i(ramp_duty_i), .pwm_o(pwm_o));
  fan_model u_fan (.clk_i(sys_clk_i), .pwm_i(pwm_o), .per_o(per), .hi_o(hi), .rises_o(rises));
  // edges since the last release of the main reset
  always @(posedge sys_clk_i)
    rel_cyc <= rst_i ? 0 : rel_cyc + 1;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string n, input logic [31:0] e, g, input int tol);
    logic [31:0] d;
    d = (g > e) ? g - e : e - g;
    checks_done++;
    if (^g === 1'bx || d > tol)
    begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_sel_i} <= {2'b11, 4'hf};
    {wb_we_i, wb_adr_i, wb_dat_i} <= {we, a, d};
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk("bus ack", 0, n > 19, 0);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    {rst_i, vbat_rst_i} <= 2'b00;
  endtask
  task automatic first_rise(output int n);
    n = 0;
    while (pwm_o !== 1'b1 && n < 9000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask
  task automatic wait_rises(input int k);
    logic [31:0] r0;
    r0 = rises;
    repeat (20000) if (rises < r0 + k) @(posedge sys_clk_i);
  endtask
  task automatic t_clamp_on;
    int n;
    do_reset();
    wb(1'b0, 12'h180, 32'h0);
    chk("freq select", 32'ha, q[3:0], 0); // default rate
    wb(1'b0, 12'h16c, 32'h0);
    chk("clamp select", 0, q[7], 0); // default delay
    wb(1'b1, 12'h004, 32'hff);
    wb(1'b0, 12'h004, 32'h0);
    chk("unmapped", 0, q, 0); // no mapped place
    wb(1'b0, 12'h184, 32'h0);
    chk("clamp active", 1, q[0], 0); // pin held
    first_rise(n);
    // clamp of 4000 cycles, then the first rise within one 800-cycle period
    chk("clamp cycles", 4402, rel_cyc, 402); // held for span
  endtask
  task automatic t_clamp_off;
    int n;
    wb(1'b1, 12'h16c, 32'h80);
    do_reset();
    wb(1'b0, 12'h16c, 32'h0);
    chk("clamp kept", 1, q[7], 0); // survives reset
    first_rise(n);
    chk("no clamp", 2000, n, 1999); // zero delay
  endtask
  task automatic t_freq;
    // 20 MHz clock cycles per period at 15, 20, 25, 30 and 25 kHz
    int pr[5] = '{1333, 1000, 800, 667, 800};
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, 12'h180, 32'h8 + i);
      wait_rises(3);
      chk("period", pr[i], per, 2); // rates
    end
  endtask
  task automatic t_duty;
    ramp_duty_i <= 8'h40;
    calc_duty_i <= 8'h5a;
    wait_rises(3);
    // a quarter of the 800-cycle period at 25 kHz
    chk("high time", 200, hi, 3); // duty
    wb(1'b0, 12'h184, 32'h0);
    chk("duties", 32'h5a4040, q[31:8], 0); // latched ramp
  endtask
  task automatic t_low;
    logic [31:0] r0;
    wb(1'b1, 12'h180, 32'h7);
    // one 25 kHz period ends within 900 cycles and the slow period starts
    repeat (900) @(posedge sys_clk_i);
    r0 = rises;
    repeat (3000) @(posedge sys_clk_i);
    chk("low rate rises", r0, rises, 0); // slow period
    chk("low rate pin", 1, pwm_o, 0); // long high time
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    final_report();
  end
  initial
  begin
    t_clamp_on();
    t_clamp_off();
    t_freq();
    t_duty();
    t_low();
    final_report();
  end
endmodule // test_fan_pwm_output_stage
`default_nettype wire
